// ---- src/aau_core.sv ----
// Accumulator ALU block: APB register slave, 128-byte register file,
// accumulator, flags and two indirect pointers; a command write executes.
// Assumes an APB3 master on pclk; pready follows the clock enable.
//
// Overview of operation
// - Pointer add sums signed 6-bit literal into chosen 16-bit pointer, no flags.
// - Pointer result wraps modulo 65536, never saturates.
// - Immediate AND writes accumulator AND literal to accumulator, zero flag only.
// - Immediate add writes accumulator plus literal, sets carry, half-carry, zero.
// - File AND combines accumulator with file byte 0..127, zero flag only.
// - File ops: destination bit 0 writes accumulator, 1 writes back to the file byte.
// - File add sums accumulator and file byte, routed by destination, three flags.
// - Shift right keeps bit 7, bit 0 to carry, updates carry and zero.
// - Add with carry sums accumulator, file byte and carry, three flags.
// - Pointer add completes in one cycle.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module aau_core
  import aau_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire aau_apb_req_s apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Core state view
  output logic [7:0] acc_value,
  output aau_flags_s flags_value,
  output logic [15:0] indirect_pointer0,
  output logic [15:0] indirect_pointer1,
  output logic exec_pulse
);

  aau_state_s s;
  aau_state_s next_s;
  aau_cmd_s cmd_w;
  aau_alu_s alu_out;
  logic [6:0] file_idx;
  logic in_file;
  logic setup;
  logic access_wr;

  // ----------------------------------------------------------------
  // Command decode from write data
  // ----------------------------------------------------------------
  always_comb
  begin
    cmd_w.op = aau_op_e'(apb_req.pwdata[AAU_CMD_OP_LSB +: 3]);
    cmd_w.dest = apb_req.pwdata[AAU_CMD_DEST_BIT];
    cmd_w.ptr_sel = apb_req.pwdata[AAU_CMD_PSEL_BIT];
    cmd_w.faddr = apb_req.pwdata[AAU_CMD_FADDR_LSB +: 7];
    cmd_w.lit = apb_req.pwdata[AAU_CMD_LIT_LSB +: 8];
  end

  aau_alu u_alu (
    .cmd(cmd_w),
    .acc(s.acc),
    .fval(s.mem[cmd_w.faddr]),
    .flags_in(s.flags),
    .ptr_in(s.indirect_pointer[cmd_w.ptr_sel]),
    .alu_out(alu_out)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign file_idx = apb_req.paddr[AAU_FILE_IDX_LSB +: 7];
  assign in_file = (apb_req.paddr[AAU_ADDR_W-1:AAU_FILE_SEL_LSB] == AAU_FILE_SEL);
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.exec_pulse = 1'b0;

    // Read data and error are captured in the setup cycle
    if (setup)
    begin
      next_s.prdata = 32'h0000_0000;
      next_s.pslverr = 1'b0;
      if (in_file)
      begin
        next_s.prdata = {24'h000000, s.mem[file_idx]};
      end
      else
      begin
        unique case (apb_req.paddr)
          AAU_CMD_OFS:
            next_s.prdata = {8'h00, s.cmd.lit, 1'b0, s.cmd.faddr, 3'h0, s.cmd.ptr_sel,
                             s.cmd.dest, s.cmd.op};
          AAU_ACC_OFS:
            next_s.prdata = {24'h000000, s.acc};
          AAU_FLAGS_OFS:
            next_s.prdata = {23'h000000, s.bad_op, 5'h00, s.flags.z,
                             s.flags.half_carry_flag, s.flags.c};
          AAU_PTR0_OFS:
            next_s.prdata = {16'h0000, s.indirect_pointer[0]};
          AAU_PTR1_OFS:
            next_s.prdata = {16'h0000, s.indirect_pointer[1]};
          AAU_LAST_OFS:
            next_s.prdata = {s.exec_cnt, 5'h00, s.cmd.op, s.last_res};
          default:
            next_s.pslverr = 1'b1;
        endcase
      end
      if (apb_req.pwrite)
      begin
        next_s.prdata = 32'h0000_0000;
      end
    end

    // Writes take effect at the completing edge
    if (access_wr && !s.pslverr)
    begin
      if (in_file)
      begin
        next_s.mem[file_idx] = apb_req.pwdata[7:0];
      end
      else
      begin
        unique case (apb_req.paddr)
          AAU_CMD_OFS:
          begin
            // Executes in this single access cycle
            next_s.cmd = cmd_w;
            next_s.exec_pulse = 1'b1;
            next_s.exec_cnt = s.exec_cnt + 16'h0001;
            if (alu_out.wr_acc || alu_out.wr_file)
            begin
              next_s.last_res = alu_out.res;
            end
            if (alu_out.wr_ptr)
            begin
              next_s.indirect_pointer[cmd_w.ptr_sel] = alu_out.ptr;
            end
            if (alu_out.wr_acc)
            begin
              next_s.acc = alu_out.res;
            end
            if (alu_out.wr_file)
            begin
              next_s.mem[cmd_w.faddr] = alu_out.res;
            end
            if (alu_out.wr_c)
            begin
              next_s.flags.c = alu_out.flags.c;
            end
            if (alu_out.wr_dc)
            begin
              next_s.flags.half_carry_flag = alu_out.flags.half_carry_flag;
            end
            if (alu_out.wr_z)
            begin
              next_s.flags.z = alu_out.flags.z;
            end
            if (alu_out.bad_op)
            begin
              next_s.bad_op = 1'b1;
            end
          end
          AAU_ACC_OFS:
            next_s.acc = apb_req.pwdata[7:0];
          AAU_FLAGS_OFS:
          begin
            next_s.flags.c = apb_req.pwdata[AAU_FLAG_C_BIT];
            next_s.flags.half_carry_flag = apb_req.pwdata[AAU_FLAG_DC_BIT];
            next_s.flags.z = apb_req.pwdata[AAU_FLAG_Z_BIT];
            // Write one to clear the bad-command flag
            if (apb_req.pwdata[AAU_FLAG_BADOP_BIT])
            begin
              next_s.bad_op = 1'b0;
            end
          end
          AAU_PTR0_OFS:
            next_s.indirect_pointer[0] = apb_req.pwdata[15:0];
          AAU_PTR1_OFS:
            next_s.indirect_pointer[1] = apb_req.pwdata[15:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= AAU_STATE_RST;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = clk_en;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign acc_value = s.acc;
  assign flags_value = s.flags;
  assign indirect_pointer0 = s.indirect_pointer[0];
  assign indirect_pointer1 = s.indirect_pointer[1];
  assign exec_pulse = s.exec_pulse;

endmodule

// ---- src/aau_pkg.sv ----
// Package for the accumulator ALU block: register map, fields, types,
// reset values and the shared add helpers.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
package aau_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int AAU_ADDR_W = 12;
  localparam logic [11:0] AAU_CMD_OFS = 12'h000;
  localparam logic [11:0] AAU_ACC_OFS = 12'h004;
  localparam logic [11:0] AAU_FLAGS_OFS = 12'h008;
  localparam logic [11:0] AAU_PTR0_OFS = 12'h00c;
  localparam logic [11:0] AAU_PTR1_OFS = 12'h010;
  localparam logic [11:0] AAU_LAST_OFS = 12'h014;
  // File window: 128 words at 0x200..0x3fc, one byte per word
  localparam logic [2:0] AAU_FILE_SEL = 3'h1;
  localparam int AAU_FILE_SEL_LSB = 9;
  localparam int AAU_FILE_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AAU_CMD_OP_LSB = 0;
  localparam int AAU_CMD_DEST_BIT = 3;
  localparam int AAU_CMD_PSEL_BIT = 4;
  localparam int AAU_CMD_FADDR_LSB = 8;
  localparam int AAU_CMD_LIT_LSB = 16;
  localparam int AAU_FLAG_C_BIT = 0;
  localparam int AAU_FLAG_DC_BIT = 1;
  localparam int AAU_FLAG_Z_BIT = 2;
  localparam int AAU_FLAG_BADOP_BIT = 8;
  localparam int AAU_LAST_OP_LSB = 8;
  localparam int AAU_LAST_CNT_LSB = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AAU_OP_POINTER_ADD_LITERAL,
    AAU_OP_AND_IMMEDIATE_TO_ACC,
    AAU_OP_ADD_IMMEDIATE_TO_ACC,
    AAU_OP_AND_ACC_WITH_FILE,
    AAU_OP_ADD_ACC_WITH_FILE,
    AAU_OP_ARITH_SHIFT_RIGHT_FILE,
    AAU_OP_ADD_ACC_FILE_WITH_CARRY
  } aau_op_e;

  typedef struct packed {
    logic [7:0] lit;
    logic [6:0] faddr;
    logic ptr_sel;
    logic dest;
    aau_op_e op;
  } aau_cmd_s;

  typedef struct packed {
    logic z;
    logic half_carry_flag;
    logic c;
  } aau_flags_s;

  typedef struct packed {
    logic [7:0] res;
    logic [15:0] ptr;
    aau_flags_s flags;
    logic wr_acc;
    logic wr_file;
    logic wr_ptr;
    logic wr_c;
    logic wr_dc;
    logic wr_z;
    logic bad_op;
  } aau_alu_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aau_apb_req_s;

  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [1:0][15:0] indirect_pointer;
    logic [7:0] acc;
    aau_flags_s flags;
    logic bad_op;
    aau_cmd_s cmd;
    logic [7:0] last_res;
    logic [15:0] exec_cnt;
    logic exec_pulse;
    logic [31:0] prdata;
    logic pslverr;
  } aau_state_s;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AAU_ACC_RST = 8'h00;
  localparam logic [15:0] AAU_PTR_RST = 16'h0000;
  localparam aau_state_s AAU_STATE_RST = '0;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  // Nine-bit sum, bit 8 is the carry out of bit 7
  function automatic logic [8:0] aau_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    return {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Carry out of bit 3
  function automatic logic aau_half(input logic [7:0] a, input logic [7:0] b,
                                    input logic cin);
    logic [4:0] t;
    t = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return t[4];
  endfunction

endpackage

// ---- src/aau_alu.sv ----
// Combinational operation unit of the accumulator ALU block.
// Assumes the caller supplies the addressed file byte and commits results.
`timescale 1ns/1ps
module aau_alu
  import aau_pkg::*;
(
  // Operation
  input wire aau_cmd_s cmd,
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire aau_flags_s flags_in,
  input wire logic [15:0] ptr_in,
  // Result
  output aau_alu_s alu_out
);

  logic [8:0] sum;
  logic [15:0] lit_ext;

  always_comb
  begin
    alu_out = '0;
    sum = 9'h000;
    lit_ext = {{10{cmd.lit[5]}}, cmd.lit[5:0]};
    unique case (cmd.op)
      AAU_OP_POINTER_ADD_LITERAL:
      begin
        alu_out.ptr = ptr_in + lit_ext;
        alu_out.wr_ptr = 1'b1;
      end
      AAU_OP_AND_IMMEDIATE_TO_ACC:
      begin
        alu_out.res = acc & cmd.lit;
        alu_out.wr_acc = 1'b1;
        alu_out.wr_z = 1'b1;
      end
      AAU_OP_ADD_IMMEDIATE_TO_ACC:
      begin
        sum = aau_add(acc, cmd.lit, 1'b0);
        alu_out.res = sum[7:0];
        alu_out.flags.c = sum[8];
        alu_out.flags.half_carry_flag = aau_half(acc, cmd.lit, 1'b0);
        alu_out.wr_acc = 1'b1;
        alu_out.wr_c = 1'b1;
        alu_out.wr_dc = 1'b1;
        alu_out.wr_z = 1'b1;
      end
      AAU_OP_AND_ACC_WITH_FILE:
      begin
        alu_out.res = acc & fval;
        alu_out.wr_acc = ~cmd.dest;
        alu_out.wr_file = cmd.dest;
        alu_out.wr_z = 1'b1;
      end
      AAU_OP_ADD_ACC_WITH_FILE:
      begin
        sum = aau_add(acc, fval, 1'b0);
        alu_out.res = sum[7:0];
        alu_out.flags.c = sum[8];
        alu_out.flags.half_carry_flag = aau_half(acc, fval, 1'b0);
        alu_out.wr_acc = ~cmd.dest;
        alu_out.wr_file = cmd.dest;
        alu_out.wr_c = 1'b1;
        alu_out.wr_dc = 1'b1;
        alu_out.wr_z = 1'b1;
      end
      AAU_OP_ARITH_SHIFT_RIGHT_FILE:
      begin
        alu_out.res = {fval[7], fval[7:1]};
        alu_out.flags.c = fval[0];
        alu_out.wr_acc = ~cmd.dest;
        alu_out.wr_file = cmd.dest;
        alu_out.wr_c = 1'b1;
        alu_out.wr_z = 1'b1;
      end
      AAU_OP_ADD_ACC_FILE_WITH_CARRY:
      begin
        sum = aau_add(acc, fval, flags_in.c);
        alu_out.res = sum[7:0];
        alu_out.flags.c = sum[8];
        alu_out.flags.half_carry_flag = aau_half(acc, fval, flags_in.c);
        alu_out.wr_acc = ~cmd.dest;
        alu_out.wr_file = cmd.dest;
        alu_out.wr_c = 1'b1;
        alu_out.wr_dc = 1'b1;
        alu_out.wr_z = 1'b1;
      end
      default:
      begin
        alu_out.bad_op = 1'b1;
      end
    endcase
    alu_out.flags.z = (alu_out.res == 8'h00);
  end

endmodule

// ---- verif/aau_core_chk.sv ----
// Checker for the accumulator ALU block: command effects on state outputs.
// Assumes it is bound to aau_core and sees only its ports.
`timescale 1ns/1ps
module aau_core_chk
  import aau_pkg::*;
(
  // Clock and control
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire aau_apb_req_s apb_req,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // State view
  input wire logic [7:0] acc_value,
  input wire aau_flags_s flags_value,
  input wire logic [15:0] indirect_pointer0,
  input wire logic [15:0] indirect_pointer1,
  input wire logic exec_pulse
);
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic go;
  logic [2:0] op;
  logic [7:0] lit;
  logic [15:0] step;
  logic [4:0] hsum;
  assign go = apb_req.psel && apb_req.penable && apb_req.pwrite && clk_en
              && apb_req.paddr == AAU_CMD_OFS;
  assign op = apb_req.pwdata[2:0];
  assign lit = apb_req.pwdata[23:16];
  assign step = {{10{lit[5]}}, lit[5:0]};
  assign hsum = {1'b0, acc_value[3:0]} + {1'b0, lit[3:0]};

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_exec_pulse: assert property (go |=> exec_pulse ##1 !exec_pulse)
    else $error("exec pulse not one cycle after command");
  chk_pulse_cause: assert property (exec_pulse |-> $past(go))
    else $error("exec pulse without command");
  chk_ptr0_sum: assert property (go && op == 3'd0 && !apb_req.pwdata[4] |=>
    indirect_pointer0 == $past(indirect_pointer0) + $past(step) && $stable(indirect_pointer1))
    else $error("pointer 0 sum wrong");
  chk_ptr1_sum: assert property (go && op == 3'd0 && apb_req.pwdata[4] |=>
    indirect_pointer1 == $past(indirect_pointer1) + $past(step) && $stable(indirect_pointer0))
    else $error("pointer 1 sum wrong");
  chk_ptr_flags: assert property (go && op == 3'd0 |=>
    $stable(flags_value) && $stable(acc_value))
    else $error("pointer add changed flags");
  chk_and_imm: assert property (go && op == 3'd1 |=>
    acc_value == ($past(acc_value) & $past(lit)) && flags_value[1:0] == $past(flags_value[1:0]))
    else $error("immediate and wrong");
  chk_add_imm: assert property (go && op == 3'd2 |=>
    {flags_value.c, acc_value} == {1'b0, $past(acc_value)} + {1'b0, $past(lit)}
    && flags_value.half_carry_flag == $past(hsum[4]) && flags_value.z == (acc_value == 8'h00))
    else $error("immediate add wrong");
  chk_and_file: assert property (go && op == 3'd3 |=>
    flags_value[1:0] == $past(flags_value[1:0]))
    else $error("file and touched carry");
  chk_file_dest: assert property (go && op inside {[3'd3:3'd6]} && apb_req.pwdata[3] |=>
    $stable(acc_value))
    else $error("file destination changed acc");
  chk_asr_acc: assert property (go && op == 3'd5 && !apb_req.pwdata[3] |=>
    acc_value[7] == acc_value[6] && flags_value.z == (acc_value == 8'h00)
    && flags_value.half_carry_flag == $past(flags_value.half_carry_flag))
    else $error("shift right wrong");
endmodule

// ---- verif/aau_core_test.sv ----
// Testbench for aau_core: command table, pointer wrap, reset, bus error.
// Assumes aau_pkg, aau_core and the checker are compiled first.
`timescale 1ns/1ps
module aau_core_test
  import aau_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] f;
    logic [2:0] pf;
    logic [31:0] cmd;
    logic [7:0] ea;
    logic [7:0] ef;
    logic [2:0] efl;
  } aau_row_s;
  logic pclk;
  logic presetn;
  logic clk_en;
  aau_apb_req_s apb_req;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [7:0] acc_value;
  aau_flags_s flags_value;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic exec_pulse;
  int err_count;
  int check_count;
  int cyc = 0;
  logic [31:0] q;
  logic e;
  aau_row_s rows [13];

  aau_core dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .acc_value(acc_value),
    .flags_value(flags_value), .indirect_pointer0(ptr0), .indirect_pointer1(ptr1),
    .exec_pulse(exec_pulse));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mk(input logic [2:0] op, input logic d,
                                     input logic [6:0] fa, input logic [7:0] k);
    return {8'h00, k, 1'b0, fa, 3'h0, 1'b0, d, op};
  endfunction
  function automatic logic [11:0] fadr(input logic [31:0] c);
    return {3'h1, c[14:8], 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    apb_req = '0;
    err_count = 0;
    check_count = 0;
    rows = '{
      '{8'hf0, 8'h00, 3'h3, mk(3'd1, 1'b0, 7'h7f, 8'h0f), 8'h00, 8'h00, 3'h7},
      '{8'h8f, 8'h11, 3'h0, mk(3'd2, 1'b0, 7'h00, 8'h71), 8'h00, 8'h11, 3'h7},
      '{8'h12, 8'h22, 3'h7, mk(3'd2, 1'b1, 7'h00, 8'h34), 8'h46, 8'h22, 3'h0},
      '{8'h3c, 8'ha5, 3'h3, mk(3'd3, 1'b0, 7'h7f, 8'h00), 8'h24, 8'ha5, 3'h3},
      '{8'h0f, 8'hf0, 3'h0, mk(3'd3, 1'b1, 7'h7f, 8'h00), 8'h0f, 8'h00, 3'h4},
      '{8'h08, 8'h08, 3'h5, mk(3'd4, 1'b0, 7'h35, 8'h00), 8'h10, 8'h08, 3'h2},
      '{8'hff, 8'h02, 3'h0, mk(3'd4, 1'b1, 7'h35, 8'h00), 8'hff, 8'h01, 3'h3},
      '{8'h00, 8'h81, 3'h2, mk(3'd5, 1'b0, 7'h00, 8'h00), 8'hc0, 8'h81, 3'h3},
      '{8'h55, 8'h01, 3'h0, mk(3'd5, 1'b1, 7'h00, 8'h00), 8'h55, 8'h00, 3'h5},
      '{8'h00, 8'h7e, 3'h1, mk(3'd5, 1'b0, 7'h7f, 8'h00), 8'h3f, 8'h7e, 3'h0},
      '{8'h0f, 8'h00, 3'h1, mk(3'd6, 1'b0, 7'h7f, 8'h00), 8'h10, 8'h00, 3'h2},
      '{8'hff, 8'h00, 3'h1, mk(3'd6, 1'b1, 7'h35, 8'h00), 8'hff, 8'h00, 3'h7},
      '{8'h80, 8'h80, 3'h0, mk(3'd6, 1'b0, 7'h00, 8'h00), 8'h00, 8'h80, 3'h5}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AAU_ACC_OFS, 32'h0);
    chk({5'h0, flags_value, acc_value, ptr0}, 32'h0);
    chk(q, 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, AAU_ACC_OFS, {24'h0, rows[i].a});
      apb(1'b1, AAU_FLAGS_OFS, {29'h0, rows[i].pf});
      apb(1'b1, fadr(rows[i].cmd), {24'h0, rows[i].f});
      apb(1'b1, AAU_CMD_OFS, rows[i].cmd);
      apb(1'b0, AAU_ACC_OFS, 32'h0);
      chk(q, {24'h0, rows[i].ea});
      apb(1'b0, AAU_FLAGS_OFS, 32'h0);
      chk(q, {29'h0, rows[i].efl});
      apb(1'b0, fadr(rows[i].cmd), 32'h0);
      chk(q, {24'h0, rows[i].ef});
    end
    // Pointer add across both ends of the range
    apb(1'b1, AAU_PTR0_OFS, 32'hfffe);
    apb(1'b1, AAU_PTR1_OFS, 32'h0010);
    apb(1'b1, AAU_FLAGS_OFS, 32'h5);
    apb(1'b1, AAU_CMD_OFS, mk(3'd0, 1'b0, 7'h0, 8'h03));
    @(negedge pclk);
    chk({ptr0, ptr1}, 32'h00010010);
    apb(1'b1, AAU_CMD_OFS, mk(3'd0, 1'b0, 7'h0, 8'h20) | 32'h10);
    @(negedge pclk);
    chk({ptr0, ptr1}, 32'h0001fff0);
    apb(1'b1, AAU_CMD_OFS, mk(3'd0, 1'b0, 7'h0, 8'hdf));
    apb(1'b0, AAU_PTR0_OFS, 32'h0);
    chk(q, 32'h0020);
    apb(1'b0, AAU_FLAGS_OFS, 32'h0);
    chk(q, 32'h5);
    // Illegal command: only the sticky flag, last op and count move
    apb(1'b1, AAU_CMD_OFS, 32'h7);
    chk({ptr0, ptr1}, 32'h0020fff0);
    chk({24'h0, acc_value}, 32'h0);
    apb(1'b0, AAU_FLAGS_OFS, 32'h0);
    chk(q, 32'h105);
    apb(1'b0, AAU_LAST_OFS, 32'h0);
    chk(q, 32'h00110700);
    apb(1'b0, AAU_CMD_OFS, 32'h0);
    chk(q, 32'h7);
    apb(1'b1, AAU_FLAGS_OFS, 32'h105);
    apb(1'b1, AAU_LAST_OFS, 32'h0);
    apb(1'b0, AAU_FLAGS_OFS, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, AAU_LAST_OFS, 32'h0);
    chk(q, 32'h00110700);
    // Enable low in the access phase stalls the bus and holds state
    fork
      apb(1'b1, AAU_ACC_OFS, 32'h5a);
      begin
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({23'h0, pready, acc_value}, 32'h0);
        clk_en <= 1'b1;
      end
    join
    @(negedge pclk);
    chk({24'h0, acc_value}, 32'h5a);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h100, 32'hff);
    chk({31'h0, e}, 32'h1);
    @(negedge pclk);
    chk({24'h0, acc_value}, 32'h5a);
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({ptr0, 5'h0, flags_value, acc_value}, 32'h0);
    chk({ptr1, 15'h0, exec_pulse}, 32'h0);
    end_sim();
  end
endmodule

bind aau_core aau_core_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .acc_value(acc_value), .flags_value(flags_value), .indirect_pointer0(indirect_pointer0),
  .indirect_pointer1(indirect_pointer1), .exec_pulse(exec_pulse));
